// ===== inc/oms_pkg.sv
package oms_pkg;

  // clock and timing
  localparam int CLK_KHZ       = 125000;
  localparam int RST_PULSE_NS  = 2000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int INIT_TIME_MS  = 2000;
  localparam int INIT_CYC      = INIT_TIME_MS * CLK_KHZ;
  localparam int LOW_POWER_SELECT_US     = 100;
  localparam int LOW_POWER_SELECT_CYC    = LOW_POWER_SELECT_US * CLK_KHZ / 1000;
  localparam int INT_OFF_US    = 500;
  localparam int INT_OFF_CYC   = INT_OFF_US * CLK_KHZ / 1000;

  // two-wire slave address, 7 bits
  localparam logic [6:0] DEV_ADDR_DEF = 7'h50;

  // register offsets
  localparam logic [7:0] ADR_INT_STATUS = 8'h02;
  localparam logic [7:0] ADR_LOS_FLAGS  = 8'h03;
  localparam logic [7:0] ADR_FAULT      = 8'h04;
  localparam logic [7:0] ADR_TX_DIS     = 8'h56;
  localparam logic [7:0] ADR_LOS_MASK   = 8'h64;
  localparam logic [7:0] ADR_FAULT_MASK = 8'h65;
  localparam logic [7:0] ADR_PAGE_SEL   = 8'h7F;
  localparam logic [7:0] ADR_SQ_DIS     = 8'hF0;
  localparam logic [7:0] ADR_RX_DIS     = 8'hF1;
  localparam logic [7:0] UPPER_BASE     = 8'h80;
  localparam logic [7:0] PAGE_CTRL      = 8'h03;

  // field positions in the interrupt status byte
  localparam int BIT_INIT_PENDING = 0;
  localparam int BIT_INT_MIRROR   = 1;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LANE_RST = 4'h0;

  // sideband sync idle levels: scl, sda, select_n, reset_n, lp
  localparam logic [4:0] SYNC_INIT = 5'h1E;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WR   = 3'h2,
    ST_WACK = 3'h6,
    ST_RD   = 3'h7,
    ST_RACK = 3'h5
  } oms_twi_state_t;

endpackage

// ===== hdl/oms_sync.sv
`timescale 1ns/1ps
module oms_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous levels in, filtered levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] agree;

  // s1 feeds s2 only; the filter looks at s2 and s3
  assign agree = ~(s2_ff ^ s3_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      dout  <= INIT;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout  <= (agree & s3_ff) | (~agree & dout);
    end
  end

endmodule

// ===== hdl/oms_flag_latch.sv
`timescale 1ns/1ps
module oms_flag_latch #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // condition levels and read clear
  input  wire logic [W-1:0] set,
  input  wire logic         clr_rd,
  output logic      [W-1:0] q
);

  // a condition present during the clearing read keeps its flag
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= (q & ~{W{clr_rd}}) | set;
    end
  end

endmodule

// ===== hdl/oms_mgmt_ctrl.sv
`timescale 1ns/1ps
module oms_mgmt_ctrl #(
  parameter int         INIT_CYCLES = oms_pkg::INIT_CYC,
  parameter logic [6:0] DEV_ADDR    = oms_pkg::DEV_ADDR_DEF
) (
  // clock and power-on reset
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  // two-wire bus
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N,
  // sideband pins
  input  wire logic       MODULE_SELECT_N,
  input  wire logic       MODULE_RESET_N,
  input  wire logic       LOW_POWER_SELECT,
  output logic            MODULE_PRESENT_N,
  output logic            INTERRUPT_N_O,
  output logic            INTERRUPT_N_OE_N,
  // lane status from the optics
  input  wire logic [1:0] RX_LOS_OPT,
  input  wire logic [3:0] TX_LOS,
  input  wire logic [3:0] TX_FAULT,
  // lane controls to the optics
  output logic      [1:0] OPT_TX_DISABLE,
  output logic      [3:0] RX_OUT_DISABLE,
  output logic      [3:0] TX_SQUELCH_EN,
  output logic      [3:0] RX_SQUELCH_EN,
  output logic            LOW_POWER_MODE,
  output logic            HS_ENABLE
);

  localparam int INIT_W = $clog2(INIT_CYCLES + 1);

  logic [4:0]             sync_q;
  logic                   scl_s;
  logic                   sda_s;
  logic                   sel_n_s;
  logic                   rst_s;
  logic                   lp_s;
  logic                   scl_d_ff;
  logic                   sda_d_ff;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  logic [8:0]             rstpin_cnt_ff;
  logic                   soft_rst_ff;
  logic                   ctrl_rst;
  logic [INIT_W-1:0]      init_cnt_ff;
  logic                   init_pending_ff;
  logic                   init_done_ff;
  oms_pkg::oms_twi_state_t state_ff;
  logic [3:0]             bit_cnt_ff;
  logic [7:0]             shreg_ff;
  logic [7:0]             tx_ff;
  logic                   rw_ff;
  logic                   first_ff;
  logic                   sda_oe_n_ff;
  logic [7:0]             ptr_ff;
  logic [7:0]             page_ff;
  logic [3:0]             tx_dis_ff;
  logic [7:0]             sq_dis_ff;
  logic [3:0]             rx_dis_ff;
  logic [7:0]             los_mask_ff;
  logic [3:0]             fault_mask_ff;
  logic [7:0]             los_q;
  logic [3:0]             fault_q;
  logic [3:0]             rx_los_lane;
  logic                   int_ff;
  logic                   nxt_int;
  logic                   rd_load;
  logic                   wr_strobe;
  logic                   ptr_load;
  logic [7:0]             rd_data;

  // upper addresses only decode on the control page
  function automatic logic addr_hit(input logic [7:0] ptr, input logic [7:0] page,
                                    input logic [7:0] target);
    addr_hit = (ptr == target) && (target < oms_pkg::UPPER_BASE || page == oms_pkg::PAGE_CTRL);
  endfunction

  oms_sync #(
    .W    (5),
    .INIT (oms_pkg::SYNC_INIT)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .din   ({SCL_I, SDA_I, MODULE_SELECT_N, MODULE_RESET_N, LOW_POWER_SELECT}),
    .dout  (sync_q)
  );

  assign scl_s   = sync_q[4];
  assign sda_s   = sync_q[3];
  assign sel_n_s = sync_q[2]; // idle level high: deselected until driven
  assign rst_s   = sync_q[1];
  assign lp_s    = sync_q[0];

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // reset pin qualifier: only a pulse past the minimum width counts
  always_ff @(posedge MCLK) begin
    if (!RSTN || rst_s) begin
      rstpin_cnt_ff <= '0;
      soft_rst_ff   <= 1'b0;
    end else if (rstpin_cnt_ff != 9'(oms_pkg::RST_PULSE_CYC)) begin
      rstpin_cnt_ff <= rstpin_cnt_ff + 9'h001;
    end else begin
      soft_rst_ff   <= 1'b1;
    end
  end

  assign ctrl_rst = !RSTN || soft_rst_ff; // power loss clears every control

  // init window opens at power-up or reset release and ends with a completion event
  always_ff @(posedge MCLK) begin
    if (ctrl_rst) begin
      init_cnt_ff     <= '0;
      init_pending_ff <= 1'b1;
      init_done_ff    <= 1'b0;
    end else if (init_pending_ff) begin
      if (init_cnt_ff == INIT_W'(INIT_CYCLES - 1)) begin
        init_pending_ff <= 1'b0;
        init_done_ff    <= 1'b1;
      end else begin
        init_cnt_ff <= init_cnt_ff + INIT_W'(1);
      end
    end else if (rd_load && addr_hit(ptr_ff, page_ff, oms_pkg::ADR_INT_STATUS)) begin
      init_done_ff <= 1'b0;
    end
  end

  // two-wire slave
  assign rd_load   = scl_fall && ((state_ff == oms_pkg::ST_AACK && rw_ff)
                                  || state_ff == oms_pkg::ST_RACK);
  assign wr_strobe = scl_fall && state_ff == oms_pkg::ST_WR && bit_cnt_ff == 4'h8 && !first_ff;
  assign ptr_load  = scl_fall && state_ff == oms_pkg::ST_WR && bit_cnt_ff == 4'h8 && first_ff;

  always_ff @(posedge MCLK) begin
    if (!RSTN || soft_rst_ff || sel_n_s) begin
      state_ff    <= oms_pkg::ST_IDLE; // deselected: no answer, no acknowledge
      sda_oe_n_ff <= 1'b1;
      bit_cnt_ff  <= 4'h0;
      shreg_ff    <= 8'h00;
      tx_ff       <= 8'h00;
      rw_ff       <= 1'b0;
      first_ff    <= 1'b0;
    end else if (start_det) begin
      state_ff    <= oms_pkg::ST_ADDR;
      sda_oe_n_ff <= 1'b1;
      bit_cnt_ff  <= 4'h0;
    end else if (stop_det) begin
      state_ff    <= oms_pkg::ST_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        oms_pkg::ST_IDLE: begin
        end
        oms_pkg::ST_ADDR, oms_pkg::ST_WR: begin
          if (scl_rise) begin
            shreg_ff   <= {shreg_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == oms_pkg::ST_WR) begin
              state_ff    <= oms_pkg::ST_WACK;
              sda_oe_n_ff <= 1'b0;
            end else if (shreg_ff[7:1] == DEV_ADDR) begin
              state_ff    <= oms_pkg::ST_AACK;
              rw_ff       <= shreg_ff[0];
              sda_oe_n_ff <= 1'b0;
            end else begin
              state_ff <= oms_pkg::ST_IDLE;
            end
          end
        end
        oms_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              state_ff    <= oms_pkg::ST_RD;
              tx_ff       <= rd_data;
              sda_oe_n_ff <= rd_data[7];
            end else begin
              state_ff    <= oms_pkg::ST_WR;
              first_ff    <= 1'b1;
              sda_oe_n_ff <= 1'b1;
            end
          end
        end
        oms_pkg::ST_WACK: begin
          if (scl_fall) begin
            state_ff    <= oms_pkg::ST_WR;
            first_ff    <= 1'b0;
            sda_oe_n_ff <= 1'b1;
          end
        end
        oms_pkg::ST_RD: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == 4'h8) begin
              state_ff    <= oms_pkg::ST_RACK;
              bit_cnt_ff  <= 4'h0;
              sda_oe_n_ff <= 1'b1;
            end else begin
              tx_ff       <= {tx_ff[6:0], 1'b0};
              sda_oe_n_ff <= tx_ff[6];
            end
          end
        end
        oms_pkg::ST_RACK: begin
          if (scl_rise && sda_s) begin
            state_ff <= oms_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state_ff    <= oms_pkg::ST_RD;
            tx_ff       <= rd_data;
            sda_oe_n_ff <= rd_data[7];
          end
        end
        default: begin
          state_ff    <= oms_pkg::ST_IDLE;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // byte pointer auto-increments after every data byte
  always_ff @(posedge MCLK) begin
    if (ctrl_rst) begin
      ptr_ff <= 8'h00;
    end else if (ptr_load) begin
      ptr_ff <= shreg_ff;
    end else if (rd_load || wr_strobe) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // soft controls; low power select leaves them untouched
  always_ff @(posedge MCLK) begin
    if (ctrl_rst) begin
      page_ff       <= oms_pkg::CTRL_RST;
      tx_dis_ff     <= oms_pkg::LANE_RST;
      sq_dis_ff     <= oms_pkg::CTRL_RST; // squelch active by default
      rx_dis_ff     <= oms_pkg::LANE_RST;
      los_mask_ff   <= oms_pkg::CTRL_RST;
      fault_mask_ff <= oms_pkg::LANE_RST;
    end else if (wr_strobe) begin
      if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_PAGE_SEL))
        page_ff <= shreg_ff;
      if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_TX_DIS))
        tx_dis_ff <= shreg_ff[3:0];
      if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_SQ_DIS))
        sq_dis_ff <= shreg_ff;
      if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_RX_DIS))
        rx_dis_ff <= shreg_ff[7:4];
      if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_LOS_MASK))
        los_mask_ff <= shreg_ff;
      if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_FAULT_MASK))
        fault_mask_ff <= shreg_ff[3:0];
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_INT_STATUS)) begin
      rd_data[oms_pkg::BIT_INIT_PENDING] = init_pending_ff;
      rd_data[oms_pkg::BIT_INT_MIRROR]   = int_ff;
    end
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_LOS_FLAGS))
      rd_data = los_q;
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_FAULT))
      rd_data = {4'h0, fault_q};
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_TX_DIS))
      rd_data = {4'h0, tx_dis_ff};
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_SQ_DIS))
      rd_data = sq_dis_ff;
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_RX_DIS))
      rd_data = {rx_dis_ff, 4'h0};
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_LOS_MASK))
      rd_data = los_mask_ff;
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_FAULT_MASK))
      rd_data = {4'h0, fault_mask_ff};
    if (addr_hit(ptr_ff, page_ff, oms_pkg::ADR_PAGE_SEL))
      rd_data = page_ff;
  end

  // each 20G optical receiver reports on both electrical lanes it carries
  assign rx_los_lane = {RX_LOS_OPT[1], RX_LOS_OPT[1], RX_LOS_OPT[0], RX_LOS_OPT[0]};

  oms_flag_latch #(
    .W (8)
  ) u_los (
    .clk    (MCLK),
    .srst   (ctrl_rst),
    .set    ({TX_LOS, rx_los_lane}),
    .clr_rd (rd_load && addr_hit(ptr_ff, page_ff, oms_pkg::ADR_LOS_FLAGS)),
    .q      (los_q)
  );

  oms_flag_latch #(
    .W (4)
  ) u_fault (
    .clk    (MCLK),
    .srst   (ctrl_rst),
    .set    (TX_FAULT),
    .clr_rd (rd_load && addr_hit(ptr_ff, page_ff, oms_pkg::ADR_FAULT)),
    .q      (fault_q)
  );

  // masks act on the next cycle, far inside the allowed time
  assign nxt_int = init_done_ff || |(los_q & ~los_mask_ff)
                   || |(fault_q & ~fault_mask_ff);

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= nxt_int;
    end
  end

  // registered lane and power outputs
  always_ff @(posedge MCLK) begin
    if (ctrl_rst) begin
      OPT_TX_DISABLE <= 2'h0;
      RX_OUT_DISABLE <= 4'h0;
      TX_SQUELCH_EN  <= 4'hF;
      RX_SQUELCH_EN  <= 4'hF;
      LOW_POWER_MODE <= 1'b0;
      HS_ENABLE      <= 1'b0;
    end else begin
      OPT_TX_DISABLE <= {|tx_dis_ff[3:2], |tx_dis_ff[1:0]};
      RX_OUT_DISABLE <= rx_dis_ff;
      TX_SQUELCH_EN  <= ~sq_dis_ff[3:0];
      RX_SQUELCH_EN  <= ~sq_dis_ff[7:4];
      LOW_POWER_MODE <= lp_s;
      HS_ENABLE      <= !lp_s && !init_pending_ff;
    end
  end

  // open-drain: drive low only, float for high
  assign SDA_O            = 1'b0;
  assign SDA_OE_N         = sda_oe_n_ff;
  assign INTERRUPT_N_O    = 1'b0;
  assign INTERRUPT_N_OE_N = !int_ff;
  assign MODULE_PRESENT_N = 1'b0;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  property p_sel_quiet;
    sel_n_s |=> SDA_OE_N && state_ff == oms_pkg::ST_IDLE;
  endproperty
  a_sel_quiet: assert property (p_sel_quiet) else $error("answered while deselected");

  property p_soft_rst;
    soft_rst_ff |=> init_pending_ff && tx_dis_ff == 4'h0 && sq_dis_ff == 8'h00;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("settings kept over reset");

  property p_init_done;
    $fell(init_pending_ff) |-> ##[1:2] !INTERRUPT_N_OE_N;
  endproperty
  a_init_done: assert property (p_init_done) else $error("no completion interrupt");

  property p_mirror;
    rd_load && addr_hit(ptr_ff, page_ff, oms_pkg::ADR_INT_STATUS) |=> tx_ff[1] == $past(int_ff);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror bit wrong");

  property p_rx_los;
    RX_LOS_OPT[1] |=> los_q[2] && los_q[3];
  endproperty
  a_rx_los: assert property (p_rx_los) else $error("rx loss not latched");

  property p_tx_los;
    TX_LOS != 4'h0 |=> (los_q[7:4] & $past(TX_LOS)) == $past(TX_LOS);
  endproperty
  a_tx_los: assert property (p_tx_los) else $error("tx loss not latched");

  property p_fault_int;
    |(fault_q & ~fault_mask_ff) |=> int_ff && !INTERRUPT_N_OE_N;
  endproperty
  a_fault_int: assert property (p_fault_int) else $error("interrupt dropped");

  property p_release;
    !nxt_int ##1 !nxt_int |-> INTERRUPT_N_OE_N;
  endproperty
  a_release: assert property (p_release) else $error("interrupt not released");

  property p_tx_mux;
    !ctrl_rst && tx_dis_ff[1] |=> OPT_TX_DISABLE[0];
  endproperty
  a_tx_mux: assert property (p_tx_mux) else $error("optical lane left on");

  property p_lp;
    $rose(lp_s) |=> LOW_POWER_MODE && !HS_ENABLE;
  endproperty
  a_lp: assert property (p_lp) else $error("low power not entered");

  c_read:   cover property (rd_load);
  c_write:  cover property (wr_strobe);
  c_reset:  cover property ($rose(soft_rst_ff));
  c_intrel: cover property ($fell(int_ff));

endmodule

// ===== test/oms_host.sv
`timescale 1ns/1ps
module oms_host (
  // pacing clock
  input  wire logic clk,
  // bus pins; the pull-up sits on the wire in the bench
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // scl stands high between frames, sda released
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one bit: 5 cycles low, 5 high (80 ns); the device reply is sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(4);
    r = sda;
    tick(1);
    scl = 1'b0;
  endtask

  // extra low time lets a device acknowledge drain before sda must be high
  task automatic start();
    tick(2);
    sda_pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(3);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(3);
    sda_pull = 1'b0;
    tick(3);
  endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int         INIT_N = 2000;
  localparam int         LIMIT  = 40000;
  localparam logic [6:0] DEV    = oms_pkg::DEV_ADDR_DEF;
  logic       mclk, rstn, sel_n, mrst_n, lps, nak;
  logic [1:0] rx_los;
  logic [3:0] tx_los, tx_fault;
  logic [7:0] rdat;
  logic       scl, pull, sda_o, sda_oe_n, present_n, int_o, int_oe_n, lpm, hs;
  logic [1:0] opt_dis;
  logic [3:0] rx_dis, tx_sq, rx_sq;
  wire        sda = ~(pull | ~sda_oe_n);
  int         err_count, n_checks, cycles;

  oms_mgmt_ctrl #(.INIT_CYCLES(INIT_N)) i_oms_mgmt_ctrl (
    .MCLK(mclk), .RSTN(rstn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_N(sda_oe_n), .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(mrst_n),
    .LOW_POWER_SELECT(lps), .MODULE_PRESENT_N(present_n), .INTERRUPT_N_O(int_o),
    .INTERRUPT_N_OE_N(int_oe_n), .RX_LOS_OPT(rx_los), .TX_LOS(tx_los),
    .TX_FAULT(tx_fault), .OPT_TX_DISABLE(opt_dis), .RX_OUT_DISABLE(rx_dis),
    .TX_SQUELCH_EN(tx_sq), .RX_SQUELCH_EN(rx_sq), .LOW_POWER_MODE(lpm), .HS_ENABLE(hs));

  oms_host i_oms_host (.clk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic summarize();
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one byte out and the acknowledge slot; a missing device acknowledge sets nak
  task automatic xb(input logic [7:0] d, input logic ai);
    logic a;
    for (int i = 7; i >= 0; i--) i_oms_host.bit_x(d[i], rdat[i]);
    i_oms_host.bit_x(ai, a);
    if (ai) nak |= a;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    nak = 1'b0;
    i_oms_host.start();
    xb({DEV, 1'b0}, 1'b1);
    xb(adr, 1'b1);
    xb(dat, 1'b1);
    i_oms_host.stop();
  endtask

  // pointer write, repeated start, one byte read and ended by a master nack
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string nm);
    logic n;
    nak = 1'b0;
    i_oms_host.start();
    xb({DEV, 1'b0}, 1'b1);
    xb(adr, 1'b1);
    i_oms_host.start();
    xb({DEV, 1'b1}, 1'b1);
    n = nak;
    xb(8'hFF, 1'b1);
    nak = n;
    i_oms_host.stop();
    chk(nm, rdat, exp);
    chk("read ack", nak, 1'b0);
  endtask

  task automatic wait_int(input int n, input logic lvl);
    int k;
    k = 0;
    while (int_oe_n !== lvl && k < n) begin
      cyc(1);
      k++;
    end
    chk("int_oe_n", int_oe_n, lvl);
  endtask

  task automatic t_init();
    chk("int idle", int_oe_n, 1'b1);
    chk("tx_sq", tx_sq, 4'hF);
    chk("rx_sq", rx_sq, 4'hF);
    chk("opt_dis", opt_dis, 2'b00);
    chk("hs", hs, 1'b0);
    chk("open drain", {sda_o, int_o, present_n}, 3'b000);
    rd(oms_pkg::ADR_INT_STATUS, 8'h01, "pending");
    wait_int(INIT_N + 20, 1'b0);
    rd(oms_pkg::ADR_INT_STATUS, 8'h02, "mirror");
    wait_int(20, 1'b1);
    chk("hs", hs, 1'b1);
  endtask

  task automatic t_sel();
    sel_n = 1'b1;
    cyc(20);
    wr(oms_pkg::ADR_TX_DIS, 8'h0F);
    chk("nak deselected", nak, 1'b1);
    sel_n = 1'b0;
    cyc(20);
    chk("opt_dis kept", opt_dis, 2'b00);
    nak = 1'b0;
    i_oms_host.start();
    xb({~DEV, 1'b0}, 1'b1);
    i_oms_host.stop();
    chk("nak wrong addr", nak, 1'b1);
  endtask

  task automatic t_ctrl();
    wr(oms_pkg::ADR_TX_DIS, 8'h04);
    cyc(5);
    chk("opt_dis", opt_dis, 2'b10);
    wr(oms_pkg::ADR_TX_DIS, 8'h02);
    cyc(5);
    chk("opt_dis", opt_dis, 2'b01);
    wr(oms_pkg::ADR_PAGE_SEL, oms_pkg::PAGE_CTRL);
    wr(oms_pkg::ADR_SQ_DIS, 8'h5A);
    wr(oms_pkg::ADR_RX_DIS, 8'h30);
    cyc(5);
    chk("write ack", nak, 1'b0);
    chk("tx_sq", tx_sq, 4'h5);
    chk("rx_sq", rx_sq, 4'hA);
    chk("rx_dis", rx_dis, 4'h3);
    rd(oms_pkg::ADR_SQ_DIS, 8'h5A, "sq_dis");
  endtask

  task automatic t_lp();
    lps = 1'b1;
    cyc(10);
    chk("lpm", lpm, 1'b1);
    chk("hs low power", hs, 1'b0);
    rd(oms_pkg::ADR_TX_DIS, 8'h02, "bus in low power");
    lps = 1'b0;
    cyc(10);
    chk("lpm", lpm, 1'b0);
    chk("hs", hs, 1'b1);
  endtask

  task automatic t_flags();
    rx_los = 2'b01;
    tx_los = 4'b1000;
    cyc(1);
    rx_los = 2'b00;
    tx_los = 4'b0000;
    wait_int(10, 1'b0);
    rd(oms_pkg::ADR_LOS_FLAGS, 8'h83, "los");
    wait_int(20, 1'b1);
    rd(oms_pkg::ADR_LOS_FLAGS, 8'h00, "los cleared");
  endtask

  task automatic t_mask();
    wr(oms_pkg::ADR_FAULT_MASK, 8'h0F);
    tx_fault = 4'h4;
    cyc(1);
    tx_fault = 4'h0;
    cyc(10);
    chk("masked int", int_oe_n, 1'b1);
    rx_los = 2'b10;
    cyc(1);
    rx_los = 2'b00;
    wait_int(10, 1'b0);
    wr(oms_pkg::ADR_FAULT_MASK, 8'h00);
    rd(oms_pkg::ADR_LOS_FLAGS, 8'h0C, "los lane2");
    cyc(10);
    chk("int held by fault", int_oe_n, 1'b0);
    rd(oms_pkg::ADR_FAULT, 8'h04, "fault");
    wait_int(20, 1'b1);
  endtask

  task automatic t_mrst();
    mrst_n = 1'b0;
    cyc(100);
    mrst_n = 1'b1;
    cyc(20);
    chk("short pulse", opt_dis, 2'b01);
    mrst_n = 1'b0;
    cyc(oms_pkg::RST_PULSE_CYC + 20);
    mrst_n = 1'b1;
    cyc(10);
    chk("opt_dis", opt_dis, 2'b00);
    chk("tx_sq", tx_sq, 4'hF);
    chk("rx_dis", rx_dis, 4'h0);
    rd(oms_pkg::ADR_INT_STATUS, 8'h01, "pending again");
    wait_int(INIT_N + 20, 1'b0);
    rd(oms_pkg::ADR_INT_STATUS, 8'h02, "reset done");
  endtask

  initial begin
    rstn = 1'b0;
    sel_n = 1'b0;
    mrst_n = 1'b1;
    lps = 1'b0;
    rx_los = 2'b00;
    tx_los = 4'h0;
    tx_fault = 4'h0;
    cyc(4);
    rstn = 1'b1;
    cyc(10);
    t_init();
    t_sel();
    t_ctrl();
    t_lp();
    t_flags();
    t_mask();
    t_mrst();
    summarize();
  end
endmodule
